/* design/lvds_clk_defs.svh */
// Register offsets, field positions, reset values and timing counts for the pixel clock synthesizer
`ifndef LVDS_CLK_DEFS_SVH
`define LVDS_CLK_DEFS_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define OFS_SOFT_RESET       8'h09
`define OFS_CLK_SRC_RANGE    8'h0a
`define OFS_CLK_RATIO_CFG    8'h0b
`define OFS_SYNTH_ENABLE     8'h0d

// ***********************************************
// Field positions
// ***********************************************
`define BIT_SOFT_RESET       0
`define BIT_SRC_SELECT       0
`define RNG_CLK_RANGE        3:1
`define BIT_EN_STATUS        7
`define RNG_DIVIDER          7:3
`define RNG_MULTIPLIER       1:0
`define BIT_SYNTH_ENABLE     0

// ***********************************************
// Reset values and limits
// ***********************************************
`define RST_SRC_SELECT       1'h0
`define RST_CLK_RANGE        3'h5
`define RST_DIVIDER          5'h00
`define RST_MULTIPLIER       2'h0
`define RST_SYNTH_ENABLE     1'h0
`define DIVIDER_MAX          5'h18
`define SRC_IS_REFERENCE     1'h0

// ***********************************************
// Timing
// ***********************************************
`define CORE_CLK_HZ          50000000
`define LOCK_WAIT_US         3000
`define LOCK_WAIT_CYCLES     ((`CORE_CLK_HZ / 1000000) * `LOCK_WAIT_US)

`endif

/* design/lvds_clk_pkg.sv */
// Types shared by the pixel clock synthesizer modules
`default_nettype none
package lvds_clk_pkg;

   typedef enum logic [1:0] {
      SYNTH_OFF,
      SYNTH_LOCKING,
      SYNTH_LOCKED
   } synth_state_e;

   typedef logic [7:0] reg_byte_t;

endpackage : lvds_clk_pkg
`default_nettype wire

/* design/lvds_ratio_divider.sv */
// Divides a stream of source clock edge pulses by the divider code plus one, codes above 24 acting as 24
`timescale 1ns/100ps
`default_nettype none
`include "lvds_clk_defs.svh"

module lvds_ratio_divider (
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // Control
   input  wire logic       run_in,
   input  wire logic [4:0] divider_code_in,
   // Source edges and result
   input  wire logic       src_edge_in,
   output var  logic       tick_out
);
   import lvds_clk_pkg::*;

   logic [4:0] count_d, count_q;
   logic       tick_d,  tick_q;
   logic [4:0] limit;

   always_comb begin
      // Reserved codes saturate so the output never runs slower than divide by 25
      limit   = (divider_code_in > `DIVIDER_MAX) ? `DIVIDER_MAX : divider_code_in;
      count_d = count_q;
      tick_d  = 1'b0;
      if (!run_in) begin
         count_d = 5'h00;
      end else if (src_edge_in) begin
         if (count_q >= limit) begin
            count_d = 5'h00;
            tick_d  = 1'b1;
         end else begin
            count_d = count_q + 5'h01;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= 5'h00;
         tick_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q  <= tick_d;
      end
   end

   assign tick_out = tick_q;

endmodule : lvds_ratio_divider
`default_nettype wire

/* design/lvds_pixel_clock_synth_config.sv */
// Configuration registers and enable sequencing of the LVDS pixel clock synthesizer
`timescale 1ns/100ps
`default_nettype none
`include "lvds_clk_defs.svh"

module lvds_pixel_clock_synth_config #(
   parameter int unsigned LOCK_CYCLES = `LOCK_WAIT_CYCLES
) (
   // Clock and reset
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_n_in,
   // Register access from the local serial port
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire lvds_clk_pkg::reg_byte_t reg_addr_in,
   input  wire lvds_clk_pkg::reg_byte_t reg_wdata_in,
   output var  lvds_clk_pkg::reg_byte_t reg_rdata_out,
   // Source clock pins
   input  wire logic                   reference_clock_input_in,
   input  wire logic                   dsi_cha_hs_clk_in,
   // Synthesizer controls
   output var  logic                   synth_enable_out,
   output var  logic                   pixel_clock_source_select_out,
   output var  logic [2:0]             clk_range_out,
   output var  logic [1:0]             reference_input_multiplier_out,
   output var  logic [4:0]             divider_code_out,
   output var  logic                   divided_tick_out,
   output var  logic                   synth_locked_out,
   output var  logic                   soft_reset_out
);
   import lvds_clk_pkg::*;

   // ***********************************************
   // Source pin synchronisers
   // ***********************************************
   logic [1:0] ref_sync_d, ref_sync_q;
   logic [1:0] dsi_sync_d, dsi_sync_q;
   logic       ref_last_d, ref_last_q;
   logic       dsi_last_d, dsi_last_q;
   logic       src_edge;

   always_comb begin
      ref_sync_d = {ref_sync_q[0], reference_clock_input_in};
      dsi_sync_d = {dsi_sync_q[0], dsi_cha_hs_clk_in};
      ref_last_d = ref_sync_q[1];
      dsi_last_d = dsi_sync_q[1];
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_sync_q <= 2'h0;
         dsi_sync_q <= 2'h0;
         ref_last_q <= 1'b0;
         dsi_last_q <= 1'b0;
      end else begin
         ref_sync_q <= ref_sync_d;
         dsi_sync_q <= dsi_sync_d;
         ref_last_q <= ref_last_d;
         dsi_last_q <= dsi_last_d;
      end
   end

   // ***********************************************
   // Configuration registers
   // ***********************************************
   logic       src_sel_d,  src_sel_q;
   logic [2:0] range_d,    range_q;
   logic [4:0] div_d,      div_q;
   logic [1:0] mult_d,     mult_q;
   logic       enable_d,   enable_q;
   logic       srst_d,     srst_q;
   reg_byte_t  rdata_d,    rdata_q;

   always_comb begin
      src_sel_d = src_sel_q;
      range_d   = range_q;
      div_d     = div_q;
      mult_d    = mult_q;
      enable_d  = enable_q;
      srst_d    = 1'b0;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `OFS_SOFT_RESET: begin
               srst_d = reg_wdata_in[`BIT_SOFT_RESET];
            end
            `OFS_CLK_SRC_RANGE: begin
               src_sel_d = reg_wdata_in[`BIT_SRC_SELECT];
               range_d   = reg_wdata_in[`RNG_CLK_RANGE];
            end
            `OFS_CLK_RATIO_CFG: begin
               div_d  = reg_wdata_in[`RNG_DIVIDER];
               mult_d = reg_wdata_in[`RNG_MULTIPLIER];
            end
            `OFS_SYNTH_ENABLE: begin
               enable_d = reg_wdata_in[`BIT_SYNTH_ENABLE];
            end
            default: begin
            end
         endcase
      end
      rdata_d = rdata_q;
      if (reg_rd_in) begin
         rdata_d = 8'h00;
         unique case (reg_addr_in)
            `OFS_CLK_SRC_RANGE: begin
               rdata_d[`BIT_EN_STATUS]  = enable_q;
               rdata_d[`RNG_CLK_RANGE]  = range_q;
               rdata_d[`BIT_SRC_SELECT] = src_sel_q;
            end
            `OFS_CLK_RATIO_CFG: begin
               rdata_d[`RNG_DIVIDER]    = div_q;
               rdata_d[`RNG_MULTIPLIER] = mult_q;
            end
            `OFS_SYNTH_ENABLE: begin
               rdata_d[`BIT_SYNTH_ENABLE] = enable_q;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_sel_q <= `RST_SRC_SELECT;
         range_q   <= `RST_CLK_RANGE;
         div_q     <= `RST_DIVIDER;
         mult_q    <= `RST_MULTIPLIER;
         enable_q  <= `RST_SYNTH_ENABLE;
         srst_q    <= 1'b0;
         rdata_q   <= 8'h00;
      end else begin
         src_sel_q <= src_sel_d;
         range_q   <= range_d;
         div_q     <= div_d;
         mult_q    <= mult_d;
         enable_q  <= enable_d;
         srst_q    <= srst_d;
         rdata_q   <= rdata_d;
      end
   end

   // ***********************************************
   // Synthesizer sequencing
   // ***********************************************
   // Settings are captured when enable rises or a soft reset restarts the sequencing; later edits do not disturb a running synthesizer
   synth_state_e state_d, state_q;
   logic         act_src_d,   act_src_q;
   logic [2:0]   act_range_d, act_range_q;
   logic [4:0]   act_div_d,   act_div_q;
   logic [1:0]   act_mult_d,  act_mult_q;
   logic [31:0]  lock_cnt_d,  lock_cnt_q;
   logic         run_div;
   logic         tick;

   always_comb begin
      state_d     = state_q;
      act_src_d   = act_src_q;
      act_range_d = act_range_q;
      act_div_d   = act_div_q;
      act_mult_d  = act_mult_q;
      lock_cnt_d  = lock_cnt_q;
      unique case (state_q)
         SYNTH_OFF: begin
            lock_cnt_d = 32'h0;
            if (enable_q) begin
               state_d     = SYNTH_LOCKING;
               act_src_d   = src_sel_q;
               act_range_d = range_q;
               act_div_d   = div_q;
               act_mult_d  = mult_q;
            end
         end
         SYNTH_LOCKING: begin
            lock_cnt_d = lock_cnt_q + 32'h1;
            if (lock_cnt_q >= LOCK_CYCLES - 1) begin
               state_d = SYNTH_LOCKED;
            end
         end
         SYNTH_LOCKED: begin
         end
      endcase
      // Soft reset restarts the synthesizer but keeps the register contents
      if (!enable_q || srst_q) begin
         state_d    = SYNTH_OFF;
         lock_cnt_d = 32'h0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q     <= SYNTH_OFF;
         act_src_q   <= `RST_SRC_SELECT;
         act_range_q <= `RST_CLK_RANGE;
         act_div_q   <= `RST_DIVIDER;
         act_mult_q  <= `RST_MULTIPLIER;
         lock_cnt_q  <= 32'h0;
      end else begin
         state_q     <= state_d;
         act_src_q   <= act_src_d;
         act_range_q <= act_range_d;
         act_div_q   <= act_div_d;
         act_mult_q  <= act_mult_d;
         lock_cnt_q  <= lock_cnt_d;
      end
   end

   // The reference path bypasses the divider and drives the tick output directly; the DSI path runs through the divider
   assign run_div  = (state_q != SYNTH_OFF) && (act_src_q != `SRC_IS_REFERENCE);
   assign src_edge = dsi_sync_q[1] & ~dsi_last_q;

   lvds_ratio_divider u_divider (
      .core_clk_in     (core_clk_in),
      .rst_n_in        (rst_n_in),
      .run_in          (run_div),
      .divider_code_in (act_div_q),
      .src_edge_in     (src_edge),
      .tick_out        (tick)
   );

   // ***********************************************
   // Output registers
   // ***********************************************
   logic       o_en_q, o_src_q, o_tick_q, o_lock_q;
   logic [2:0] o_rng_q;
   logic [1:0] o_mult_q;
   logic [4:0] o_div_q;
   logic       ref_edge;

   assign ref_edge = ref_sync_q[1] & ~ref_last_q;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         o_en_q   <= 1'b0;
         o_src_q  <= `RST_SRC_SELECT;
         o_rng_q  <= `RST_CLK_RANGE;
         o_mult_q <= `RST_MULTIPLIER;
         o_div_q  <= `RST_DIVIDER;
         o_tick_q <= 1'b0;
         o_lock_q <= 1'b0;
      end else begin
         o_en_q   <= (state_d != SYNTH_OFF);
         o_src_q  <= act_src_d;
         o_rng_q  <= act_range_d;
         o_mult_q <= (act_src_d == `SRC_IS_REFERENCE) ? act_mult_d : `RST_MULTIPLIER;
         o_div_q  <= (act_src_d == `SRC_IS_REFERENCE) ? `RST_DIVIDER : act_div_d;
         o_tick_q <= run_div ? tick : (state_q != SYNTH_OFF) & ref_edge;
         o_lock_q <= (state_d == SYNTH_LOCKED);
      end
   end

   assign reg_rdata_out                  = rdata_q;
   assign synth_enable_out               = o_en_q;
   assign pixel_clock_source_select_out  = o_src_q;
   assign clk_range_out                  = o_rng_q;
   assign reference_input_multiplier_out = o_mult_q;
   assign divider_code_out               = o_div_q;
   assign divided_tick_out               = o_tick_q;
   assign synth_locked_out               = o_lock_q;
   assign soft_reset_out                 = srst_q;

endmodule : lvds_pixel_clock_synth_config
`default_nettype wire

/* dv/lvds_pixel_clock_synth_config_props.sv */
// Assertion checker for the pixel clock synthesizer configuration block
`timescale 1ns/100ps
`default_nettype none
`include "lvds_clk_defs.svh"

module lvds_pixel_clock_synth_config_chk #(
   parameter int unsigned LOCK_CYCLES = 20
) (
   // Clock and reset
   input wire logic                    core_clk_in,
   input wire logic                    rst_n_in,
   // Register port
   input wire logic                    reg_wr_in,
   input wire logic                    reg_rd_in,
   input wire lvds_clk_pkg::reg_byte_t reg_addr_in,
   input wire lvds_clk_pkg::reg_byte_t reg_wdata_in,
   input wire lvds_clk_pkg::reg_byte_t reg_rdata_out,
   // Source clocks
   input wire logic                    reference_clock_input_in,
   input wire logic                    dsi_cha_hs_clk_in,
   // Synthesizer controls
   input wire logic                    synth_enable_out,
   input wire logic                    pixel_clock_source_select_out,
   input wire logic [2:0]              clk_range_out,
   input wire logic [1:0]              reference_input_multiplier_out,
   input wire logic [4:0]              divider_code_out,
   input wire logic                    divided_tick_out,
   input wire logic                    synth_locked_out,
   input wire logic                    soft_reset_out
);
   // ***********************************************
   // Properties
   // ***********************************************
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic wr_en;
   assign wr_en = reg_wr_in && reg_addr_in == `OFS_SYNTH_ENABLE;
   // Cycles the synthesizer has run since it last started
   logic [31:0] run_cnt_q;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_cnt_q <= 32'h0;
      end else if (!synth_enable_out) begin
         run_cnt_q <= 32'h0;
      end else begin
         run_cnt_q <= run_cnt_q + 32'h1;
      end
   end
   AST_LOCK_TIME: assert property ($rose(synth_locked_out) |-> run_cnt_q == LOCK_CYCLES)
      else $error("lock not after the lock time");
   AST_EN_START: assert property (wr_en && reg_wdata_in[0] && !synth_enable_out |-> ##[1:3] synth_enable_out)
      else $error("start missing");
   AST_EN_STOP: assert property (wr_en && !reg_wdata_in[0] |-> ##[1:3] !synth_enable_out)
      else $error("stop missing");
   AST_HOLD: assert property (synth_enable_out && $past(synth_enable_out) |-> $stable({pixel_clock_source_select_out,
      clk_range_out, reference_input_multiplier_out, divider_code_out}))
      else $error("settings moved");
   AST_DIV_REF: assert property (!pixel_clock_source_select_out |-> divider_code_out == 5'h00)
      else $error("divider not zero");
   AST_MUL_DSI: assert property (pixel_clock_source_select_out |-> reference_input_multiplier_out == 2'h0)
      else $error("multiplier not zero");
   AST_LOCK: assert property ($rose(synth_enable_out) |-> (!synth_locked_out) [*8] ##[1:40] synth_locked_out)
      else $error("lock timing");
   AST_LOCK_EN: assert property (synth_locked_out |-> synth_enable_out)
      else $error("lock while off");
   AST_SOFT: assert property (reg_wr_in && reg_addr_in == `OFS_SOFT_RESET && reg_wdata_in[0]
      |-> ##[1:2] soft_reset_out ##1 !soft_reset_out)
      else $error("soft reset pulse");
   AST_RD_EN: assert property (reg_rd_in && reg_addr_in == `OFS_SYNTH_ENABLE |=> reg_rdata_out[7:1] == 7'h00)
      else $error("reserved bits set");
endmodule : lvds_pixel_clock_synth_config_chk

bind lvds_pixel_clock_synth_config lvds_pixel_clock_synth_config_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (.*);
`default_nettype wire

/* dv/lvds_pixel_clock_synth_config_tb.sv */
// Self-checking bench for the pixel clock synthesizer configuration block
`timescale 1ns/100ps
`default_nettype none
`include "lvds_clk_defs.svh"

module lvds_pixel_clock_synth_config_tb;
   import lvds_clk_pkg::*;
   // ***********************************************
   // Stimulus and checks
   // ***********************************************
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, refc = 0, dsic = 0;
   reg_byte_t addr = 8'h00, wdata = 8'h00, rdata;
   logic en, sel, locked, tick, srst;
   logic [2:0] rng;
   logic [1:0] mul;
   logic [4:0] div;
   int miscompares = 0, cmp_count = 0, ticks = 0, t0;
   initial forever #10 clk = ~clk;
   lvds_pixel_clock_synth_config #(.LOCK_CYCLES(20)) lvds_pixel_clock_synth_config_i (
      .core_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reference_clock_input_in(refc), .dsi_cha_hs_clk_in(dsic),
      .synth_enable_out(en), .pixel_clock_source_select_out(sel), .clk_range_out(rng),
      .reference_input_multiplier_out(mul), .divider_code_out(div), .divided_tick_out(tick),
      .synth_locked_out(locked), .soft_reset_out(srst));
   always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
   task automatic summarize;
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr_reg(reg_byte_t a, reg_byte_t d);
      @(posedge clk); wr <= 1; addr <= a; wdata <= d;
      @(posedge clk); wr <= 0;
   endtask : wr_reg
   task automatic rd_reg(reg_byte_t a, reg_byte_t e);
      @(posedge clk); rd <= 1; addr <= a;
      @(posedge clk); rd <= 0;
      @(posedge clk); chk("rdata", {8'h00, rdata}, {8'h00, e});
   endtask : rd_reg
   // Slow source edges so the two-flop synchroniser sees every one
   task automatic edges(logic dsi, int n);
      repeat (n) begin
         @(posedge clk); if (dsi) dsic <= 1; else refc <= 1;
         repeat (3) @(posedge clk); dsic <= 0; refc <= 0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask : edges
   task automatic wait_lock;
      int i;
      for (i = 0; i < 100 && locked !== 1'b1; i++) @(posedge clk);
      if (locked !== 1'b1) begin
         miscompares++;
         summarize();
      end
   endtask : wait_lock
   task automatic settings(logic [15:0] e);
      chk("settings", {5'h00, sel, rng, mul, div}, e);
   endtask : settings
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      settings(16'h0280);
      chk("enable", {15'h0, en}, 16'h0000);
      rd_reg(8'h0a, 8'h0a);
      rd_reg(8'h0b, 8'h00);
      rd_reg(8'h0d, 8'h00);
      rd_reg(8'h09, 8'h00);
      rd_reg(8'h0c, 8'h00);
      // DSI source, divide by 3, multiplier left at zero
      wr_reg(8'h0b, 8'h10);
      wr_reg(8'h0a, 8'h03);
      // Source runs before enable; nothing may come out while off
      t0 = ticks;
      edges(1, 3);
      chk("ticks", 16'(ticks - t0), 16'h0000);
      wr_reg(8'h0d, 8'h01);
      rd_reg(8'h0a, 8'h83);
      wait_lock();
      settings(16'h0482);
      t0 = ticks;
      edges(1, 9);
      chk("ticks", 16'(ticks - t0), 16'h0003);
      // Edits while running must not reach the synthesizer
      wr_reg(8'h0b, 8'hc0);
      settings(16'h0482);
      rd_reg(8'h0b, 8'hc0);
      wr_reg(8'h0d, 8'h00);
      repeat (3) @(posedge clk);
      chk("enable", {15'h0, en}, 16'h0000);
      wr_reg(8'h0d, 8'h01);
      wait_lock();
      settings(16'h0498);
      t0 = ticks;
      edges(1, 50);
      chk("ticks", 16'(ticks - t0), 16'h0002);
      // Reference source, multiply by 4
      wr_reg(8'h0d, 8'h00);
      wr_reg(8'h0b, 8'h03);
      wr_reg(8'h0a, 8'h0a);
      wr_reg(8'h0d, 8'h01);
      wait_lock();
      settings(16'h02e0);
      t0 = ticks;
      edges(0, 5);
      chk("ticks", 16'(ticks - t0), 16'h0005);
      // Soft reset keeps the registers and restarts the sequencing
      wr_reg(8'h09, 8'h01);
      @(posedge clk);
      chk("soft reset", {15'h0, srst}, 16'h0001);
      rd_reg(8'h0b, 8'h03);
      rd_reg(8'h09, 8'h00);
      chk("soft reset", {15'h0, srst}, 16'h0000);
      chk("locked", {15'h0, locked}, 16'h0000);
      wait_lock();
      chk("enable", {15'h0, en}, 16'h0001);
      // Reserved divider codes run no slower than divide by 25
      wr_reg(8'h0d, 8'h00);
      wr_reg(8'h0b, 8'hf8);
      wr_reg(8'h0a, 8'h03);
      wr_reg(8'h0d, 8'h01);
      wait_lock();
      settings(16'h049f);
      t0 = ticks;
      edges(1, 50);
      chk("ticks", 16'(ticks - t0), 16'h0002);
      summarize();
   end
endmodule : lvds_pixel_clock_synth_config_tb
`default_nettype wire
